// ===== common/pci_write_cfg.svh
// constants of the target memory write path: pci codes, status bits, register map, reset values
// assumes inclusion by bare name from the package and design files
`ifndef PCI_WRITE_CFG_SVH
`define PCI_WRITE_CFG_SVH
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_WRITE_INV 4'hF
`define TSR_W 12
`define TSR_BAR_LSB 0
`define TSR_BAR_MSB 5
`define TSR_WIDE 7
`define TSR_BUSY 8
`define TSR_BURST 9
`define TSR_PCI_XFER 10
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_XFER_COUNT 12'h008
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0001
`define STATUS_STATE_LSB 16
`define BUF_DEPTH 2
`endif

// ===== common/pci_write_pkg.sv
// types shared by the target write path modules
// assumes pci_write_cfg.svh is reachable on the include path
package pci_write_pkg;
  `include "pci_write_cfg.svh"
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_CLAIM = 3'b010,
    ST_DATA = 3'b011,
    ST_TURNOFF = 3'b100,
    ST_RELEASE = 3'b101
  } wr_state_e;
  typedef logic [`TSR_W-1:0] tsr_t;
endpackage

// ===== common/word_stream_if.sv
// valid/ready word stream with fill level, joining the write path to its holding buffer
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface word_stream_if #(parameter int W = 72) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [1:0] count;
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, count);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, count);
endinterface

// ===== design/pci_target_memory_write_path.sv
// target-side memory write datapath and handshake of a pci target, with local stream and status vector
// assumes pci pins are synchronous to pclk and address decode supplies bar hits in the cycle after the address
//
// Function
// - register ad and byte enables, drive locally
// - assert data valid with registered data
// - transfer strobe when valid and prior ready
// - status bit 10 marks previous pci transfer
// - after last phase drive controls high once
// - next cycle clear status, release controls
// - one cycle later deassert local frame, or once the buffer drains
// - tolerate master and local wait states
// - status bit 9 flags burst detection
// - zero-wait burst streams one clock later
// - master wait drops data valid next cycle, or once the buffer drains
// - withhold trdy until local ready seen
// - claim asserts local frame, bit 7 wide
// - status bit 8 busy while pci occupied
`timescale 1ns/1ns
`include "pci_write_cfg.svh"
module pci_target_memory_write_path
  import pci_write_pkg::*;
#(
  parameter int AD_W = 64,
  parameter int BE_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [AD_W-1:0] ad_in,
  input wire logic [BE_W-1:0] cben_in,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic req64_n_in,
  input wire logic [5:0] bar_hit,
  output logic trdy_n_out,
  output logic trdy_n_oe,
  output logic devsel_n_out,
  output logic devsel_n_oe,
  output logic ack64_n_out,
  output logic ack64_n_oe,
  output logic stop_n_out,
  output logic stop_n_oe,
  output logic [AD_W-1:0] local_data_out,
  output logic [BE_W-1:0] local_be_out,
  output logic local_data_valid_n,
  input wire logic local_ready_in_n,
  output logic local_transfer_strobe_n,
  output logic local_frame_active_n,
  output tsr_t target_status_vector
);
  localparam int W = AD_W + BE_W;

  if (!(AD_W == 32 || AD_W == 64) || BE_W != AD_W / 8) begin : g_width_check
    $error("write path supports 32 or 64 bit ad with one enable per byte");
  end

  wr_state_e state;
  logic target_enable;
  logic count_clear;
  logic [31:0] xfer_count;
  logic wide_q;
  logic ready_q;
  logic pins_oe;
  logic phase_done;
  logic last_phase;
  logic pop;
  logic [2:0] fill_after;
  logic next_trdy;
  logic cmd_is_write;

  word_stream_if #(.W(W)) ws ();

  two_entry_buffer #(.W(W)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .s(ws.store)
  );

  write_path_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status_word({13'h0000, state, 4'h0, target_status_vector}),
    .xfer_count(xfer_count),
    .target_enable(target_enable),
    .count_clear(count_clear)
  );

  assign cmd_is_write = (cben_in[3:0] == `CMD_MEM_WRITE) || (cben_in[3:0] == `CMD_MEM_WRITE_INV);
  assign phase_done = (state == ST_DATA) && !trdy_n_out && !irdy_n_in;
  assign last_phase = phase_done && frame_n_in;

  // a completed data phase enters the buffer and is shown from a flip-flop next cycle if the buffer was empty
  assign ws.in_valid = phase_done;
  assign ws.in_data = {be_mask(cben_in), ad_in};
  assign ws.out_ready = ready_q;
  assign local_data_out = ws.out_data[AD_W-1:0];
  assign local_be_out = ws.out_data[W-1:AD_W];
  assign local_data_valid_n = !ws.out_valid;
  assign pop = ws.out_valid && ready_q;
  assign local_transfer_strobe_n = !pop;

  assign trdy_n_oe = pins_oe;
  assign devsel_n_oe = pins_oe;
  assign ack64_n_oe = pins_oe;
  assign stop_n_oe = pins_oe;
  assign stop_n_out = 1'b1;

  function automatic logic [BE_W-1:0] be_mask(input logic [BE_W-1:0] cb);
    return cb;
  endfunction

  // the buffer must keep room for one word in flight after trdy is granted
  assign fill_after = 3'({1'b0, ws.count} + {2'b00, phase_done} - {2'b00, pop});
  assign next_trdy = (state == ST_DATA) && !last_phase && !local_ready_in_n && (fill_after <= 3'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= !local_ready_in_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      wide_q <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!frame_n_in && cmd_is_write && target_enable) begin
            state <= ST_DECODE;
            wide_q <= !req64_n_in;
          end
        end
        ST_DECODE: begin
          state <= (bar_hit != 6'h00) ? ST_CLAIM : ST_IDLE;
        end
        ST_CLAIM: begin
          state <= ST_DATA;
        end
        ST_DATA: begin
          if (last_phase) begin
            state <= ST_TURNOFF;
          end
        end
        ST_TURNOFF: begin
          state <= ST_RELEASE;
        end
        ST_RELEASE: begin
          // local frame stays up while the buffer still holds write data
          if (ws.count == 2'd0) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trdy_n_out <= 1'b1;
      devsel_n_out <= 1'b1;
      ack64_n_out <= 1'b1;
      pins_oe <= 1'b0;
    end else begin
      trdy_n_out <= !next_trdy;
      if (state == ST_DECODE && bar_hit != 6'h00) begin
        pins_oe <= 1'b1;
      end else if (state == ST_CLAIM) begin
        devsel_n_out <= 1'b0;
        ack64_n_out <= !wide_q;
      end else if (last_phase) begin
        devsel_n_out <= 1'b1;
        ack64_n_out <= 1'b1;
      end else if (state == ST_TURNOFF) begin
        pins_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_status_vector <= '0;
    end else if (state == ST_TURNOFF || (state == ST_DECODE && bar_hit == 6'h00)) begin
      target_status_vector <= '0;
    end else begin
      if (state == ST_DECODE) begin
        target_status_vector[`TSR_BAR_MSB:`TSR_BAR_LSB] <= bar_hit;
        target_status_vector[`TSR_WIDE] <= wide_q;
        target_status_vector[`TSR_BUSY] <= 1'b1;
      end
      if ((state == ST_DECODE || state == ST_CLAIM || state == ST_DATA) && !frame_n_in && !irdy_n_in) begin
        target_status_vector[`TSR_BURST] <= 1'b1;
      end
      if (state == ST_DATA || state == ST_CLAIM) begin
        target_status_vector[`TSR_PCI_XFER] <= phase_done;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_frame_active_n <= 1'b1;
    end else if (state == ST_DECODE && bar_hit != 6'h00) begin
      local_frame_active_n <= 1'b0;
    end else if (state == ST_RELEASE && ws.count == 2'd0) begin
      local_frame_active_n <= 1'b1;
    end
  end

  // counting local transfers; a transfer in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_count <= 32'h0000_0000;
    end else if (count_clear) begin
      xfer_count <= {31'h0000_0000, pop};
    end else if (pop) begin
      xfer_count <= xfer_count + 32'h0000_0001;
    end
  end

  sequence s_last_phase;
    last_phase;
  endsequence

  sequence s_turnoff_then_release;
    (trdy_n_out && devsel_n_out && ack64_n_out && stop_n_out && pins_oe)
      ##1 (!pins_oe && target_status_vector == '0);
  endsequence

  property p_data_follows;
    @(posedge pclk) disable iff (!presetn)
      phase_done && ws.count == 2'd0 |=> !local_data_valid_n && local_data_out == $past(ad_in)
        && local_be_out == $past(cben_in);
  endproperty
  a_data_follows: assert property (p_data_follows) else $error("write data not shown one clock after phase");

  property p_stream;
    @(posedge pclk) disable iff (!presetn)
      phase_done && ready_q && ws.count == 2'd0 ##1 phase_done && ready_q |=> !local_data_valid_n
        && (local_transfer_strobe_n == !ready_q);
  endproperty
  a_stream: assert property (p_stream) else $error("zero wait burst word did not stream");

  property p_strobe;
    @(posedge pclk) disable iff (!presetn)
      !local_transfer_strobe_n == (!local_data_valid_n && !$past(local_ready_in_n));
  endproperty
  a_strobe: assert property (p_strobe) else $error("transfer strobe disagrees with valid and prior ready");

  property p_pci_xfer_bit;
    @(posedge pclk) disable iff (!presetn)
      phase_done |=> target_status_vector[`TSR_PCI_XFER];
  endproperty
  a_pci_xfer_bit: assert property (p_pci_xfer_bit) else $error("status bit 10 missing after pci transfer");

  property p_end_sequence;
    @(posedge pclk) disable iff (!presetn)
      s_last_phase |=> s_turnoff_then_release;
  endproperty
  a_end_sequence: assert property (p_end_sequence) else $error("turn-off and release did not follow last phase");

  property p_frame_end;
    @(posedge pclk) disable iff (!presetn)
      $fell(pins_oe) && ws.count == 2'd0 |=> local_frame_active_n;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("local frame not dropped after status clear");

  property p_burst;
    @(posedge pclk) disable iff (!presetn)
      state == ST_DATA && !frame_n_in && !irdy_n_in && !last_phase |=> target_status_vector[`TSR_BURST];
  endproperty
  a_burst: assert property (p_burst) else $error("burst bit not set");

  property p_master_wait;
    @(posedge pclk) disable iff (!presetn)
      !phase_done && ws.count == 2'd0 |=> local_data_valid_n && local_transfer_strobe_n;
  endproperty
  a_master_wait: assert property (p_master_wait) else $error("data valid held across master wait");

  property p_trdy_needs_ready;
    @(posedge pclk) disable iff (!presetn)
      $fell(trdy_n_out) |-> !$past(local_ready_in_n);
  endproperty
  a_trdy_needs_ready: assert property (p_trdy_needs_ready) else $error("trdy granted without local ready");

  property p_claim;
    @(posedge pclk) disable iff (!presetn)
      state == ST_DECODE && bar_hit != 6'h00 |=> !local_frame_active_n
        && target_status_vector[`TSR_WIDE] == $past(wide_q) && target_status_vector[`TSR_BUSY];
  endproperty
  a_claim: assert property (p_claim) else $error("claim did not raise local frame and width bit");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
      state == ST_DATA || state == ST_TURNOFF |-> target_status_vector[`TSR_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit low while pci side occupied");

  property p_room;
    @(posedge pclk) disable iff (!presetn)
      phase_done |-> ws.in_ready;
  endproperty
  a_room: assert property (p_room) else $error("pci phase completed with the buffer full");
endmodule // pci_target_memory_write_path

// ===== design/two_entry_buffer.sv
// two-entry flip-flop buffer with valid/ready on both sides
// assumes the store modport of word_stream_if and one clock
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int W = 72
) (
  input wire logic pclk,
  input wire logic presetn,
  word_stream_if.store s
);
  logic [W-1:0] slot [0:1];
  logic rd_idx;
  logic wr_idx;
  logic [1:0] fill;
  logic push;
  logic pop;

  assign push = s.in_valid && s.in_ready;
  assign pop = s.out_valid && s.out_ready;
  assign s.in_ready = (fill != 2'd2);
  assign s.out_valid = (fill != 2'd0);
  assign s.out_data = slot[rd_idx];
  assign s.count = fill;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= 2'd0;
    end else begin
      fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx <= 1'b0;
      wr_idx <= 1'b0;
    end else begin
      if (push) begin
        wr_idx <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      slot[wr_idx] <= s.in_data;
    end
  end
endmodule // two_entry_buffer

// ===== design/write_path_regs.sv
// apb slave holding control, status and transfer count words of the write path
// assumes a zero-wait apb master on pclk; status and count come from the write path
`timescale 1ns/1ns
`include "pci_write_cfg.svh"
module write_path_regs
  import pci_write_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] status_word,
  input wire logic [31:0] xfer_count,
  output logic target_enable,
  output logic count_clear
);
  logic [31:0] ctrl;
  logic mapped;
  logic access;

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_XFER_COUNT);
  endfunction

  assign mapped = is_mapped(paddr);
  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign target_enable = ctrl[`CTRL_ENABLE_BIT];
  assign count_clear = access && pwrite && (paddr == `REG_XFER_COUNT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
    end else if (access && pwrite && paddr == `REG_CTRL) begin
      ctrl <= {31'h0000_0000, pwdata[`CTRL_ENABLE_BIT]};
    end
  end

  // read data is loaded in the setup cycle so it comes from a flip-flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `REG_CTRL: prdata <= ctrl;
        `REG_STATUS: prdata <= status_word;
        `REG_XFER_COUNT: prdata <= xfer_count;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // write_path_regs

// ===== test/pci_master_model.sv
// pci bus master model issuing memory write transactions
// assumes the target's trdy is sampled at the rising edge of pclk
`timescale 1ns/1ns
module pci_master_model (
  input wire logic pclk,
  input wire logic trdy_n_out,
  output logic [63:0] ad_in,
  output logic [7:0] cben_in,
  output logic frame_n_in,
  output logic irdy_n_in,
  output logic req64_n_in
);
  initial begin
    ad_in = 64'h0;
    cben_in = 8'hFF;
    frame_n_in = 1'b1;
    irdy_n_in = 1'b1;
    req64_n_in = 1'b1;
  end
  // n data phases from base, one master wait after phase w
  task automatic run(input int n, input logic [63:0] base, input int w);
    int i;
    int guard;
    i = 0;
    guard = 0;
    @(posedge pclk);
    frame_n_in <= 1'b0;
    req64_n_in <= 1'b0;
    ad_in <= 64'h0000_0000_0000_1000;
    cben_in <= 8'h07;
    @(posedge pclk);
    ad_in <= base;
    cben_in <= 8'h00;
    irdy_n_in <= (w == 0);
    frame_n_in <= (n == 1);
    req64_n_in <= (n == 1);
    // w of zero holds off irdy in the first data phase for 8 clocks
    if (w == 0) begin
      repeat (7) @(posedge pclk);
    end
    while (i < n && guard < 40) begin
      @(posedge pclk);
      guard++;
      if (irdy_n_in === 1'b1) begin
        irdy_n_in <= 1'b0;
      end else if (trdy_n_out === 1'b0) begin
        i++;
        // released bus shows the inverse of its last value
        ad_in <= (i == n) ? ~ad_in : base + 64'(i);
        cben_in <= (i == n) ? ~cben_in : 8'(i);
        frame_n_in <= (i >= n - 1);
        req64_n_in <= (i >= n - 1);
        irdy_n_in <= (i == n) || (i == w);
      end
    end
    if (i < n) begin
      @(posedge pclk);
      frame_n_in <= 1'b1;
      irdy_n_in <= 1'b1;
      req64_n_in <= 1'b1;
    end
  endtask
endmodule // pci_master_model

// ===== test/pci_target_memory_write_path_tb.sv
// self-checking bench of the target memory write path
// assumes pci_master_model as the bus master and the bench as local side and apb master
`timescale 1ns/1ns
module pci_target_memory_write_path_tb;
  import pci_write_pkg::*;
  `include "pci_write_cfg.svh"
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] ad_in, local_data_out;
  logic [7:0] cben_in, local_be_out;
  logic frame_n_in, irdy_n_in, req64_n_in, er;
  logic [5:0] bar_hit;
  logic trdy_n_out, trdy_n_oe, devsel_n_out, devsel_n_oe, ack64_n_out, ack64_n_oe, stop_n_out, stop_n_oe;
  logic local_data_valid_n, local_ready_in_n, local_transfer_strobe_n, local_frame_active_n;
  tsr_t target_status_vector, tsr_seen;
  logic [71:0] got[$];
  int fail_count, compares, cyc, run_len, max_run, clear_cyc, frame_cyc;
  logic stall, was_oe, was_frame, last_hi, end_hi, clear_ok, claim_seen;

  pci_target_memory_write_path i_pci_target_memory_write_path (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ad_in(ad_in), .cben_in(cben_in), .frame_n_in(frame_n_in),
    .irdy_n_in(irdy_n_in), .req64_n_in(req64_n_in), .bar_hit(bar_hit), .trdy_n_out(trdy_n_out),
    .trdy_n_oe(trdy_n_oe), .devsel_n_out(devsel_n_out), .devsel_n_oe(devsel_n_oe),
    .ack64_n_out(ack64_n_out), .ack64_n_oe(ack64_n_oe), .stop_n_out(stop_n_out), .stop_n_oe(stop_n_oe),
    .local_data_out(local_data_out), .local_be_out(local_be_out), .local_data_valid_n(local_data_valid_n),
    .local_ready_in_n(local_ready_in_n), .local_transfer_strobe_n(local_transfer_strobe_n),
    .local_frame_active_n(local_frame_active_n), .target_status_vector(target_status_vector));

  pci_master_model i_pci_master_model (.pclk(pclk), .trdy_n_out(trdy_n_out), .ad_in(ad_in),
    .cben_in(cben_in), .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in), .req64_n_in(req64_n_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report;
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [71:0] exp, input logic [71:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // local side monitor and stall pattern, sampled at each rising edge
  always @(posedge pclk) begin
    cyc++;
    local_ready_in_n <= stall && (cyc % 4 != 0);
    if (local_transfer_strobe_n === 1'b0) begin
      got.push_back({local_data_out, local_be_out});
      run_len++;
    end else begin
      run_len = 0;
    end
    if (run_len > max_run) max_run = run_len;
    tsr_seen = tsr_seen | target_status_vector;
    if (devsel_n_oe === 1'b1) claim_seen = 1'b1;
    if (devsel_n_oe === 1'b0 && was_oe) begin
      clear_cyc = cyc;
      end_hi = last_hi;
      clear_ok = (target_status_vector === '0) && (trdy_n_oe === 1'b0);
    end
    if (local_frame_active_n === 1'b1 && !was_frame) frame_cyc = cyc;
    last_hi = devsel_n_oe && trdy_n_out && devsel_n_out && ack64_n_out && stop_n_out;
    was_oe = devsel_n_oe === 1'b1;
    was_frame = local_frame_active_n === 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic txn(input string nm, input int n, input int w, input logic st);
    int k, t0;
    logic [63:0] base;
    base = 64'hA5C3_0000_0000_0000 + 64'(n * 256);
    got.delete();
    tsr_seen = '0;
    max_run = 0;
    stall = st;
    t0 = cyc;
    i_pci_master_model.run(n, base, w);
    for (k = 0; k < 80 && frame_cyc <= t0; k++) @(posedge pclk);
    stall = 1'b0;
    check({nm, " words"}, 72'(n), 72'(got.size()));
    for (k = 0; k < got.size(); k++) check({nm, " word"}, {base + 64'(k), 8'(k)}, got[k]);
    check({nm, " burst"}, 72'(n > 1), 72'(tsr_seen[`TSR_BURST]));
    check({nm, " wide"}, 72'h1, 72'({tsr_seen[`TSR_WIDE], tsr_seen[0]} == 2'b11));
    check({nm, " busy"}, 72'h1, 72'(tsr_seen[`TSR_BUSY]));
    check({nm, " pci xfer"}, 72'h1, 72'(tsr_seen[`TSR_PCI_XFER]));
    check({nm, " frame end"}, 72'h1, 72'(frame_cyc > t0));
    check({nm, " drive high"}, 72'h1, 72'(end_hi));
    check({nm, " clear"}, 72'h1, 72'(clear_ok));
    if (!st) check({nm, " frame gap"}, 72'h1, 72'(frame_cyc - clear_cyc));
    if (!st && w <= 0) check({nm, " stream"}, 72'(n), 72'(max_run));
    if (w > 0) check({nm, " valid drop"}, 72'h1, 72'(max_run < n));
  endtask

  task automatic test_single;
    txn("single", 1, -1, 1'b0);
  endtask

  task automatic test_burst;
    txn("burst", 5, -1, 1'b0);
  endtask

  task automatic test_master_wait;
    txn("master wait", 5, 2, 1'b0);
  endtask

  task automatic test_local_stall;
    txn("local stall", 6, -1, 1'b1);
  endtask

  task automatic test_late_irdy;
    txn("late irdy", 3, 0, 1'b0);
  endtask

  task automatic test_regs;
    apb(1'b0, `REG_CTRL, 32'h0);
    check("ctrl reset", 72'(`CTRL_RESET), 72'(rd));
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped err", 72'h1, 72'(er));
    apb(1'b0, `REG_XFER_COUNT, 32'h0);
    check("xfer count", 72'd17, 72'(rd));
    apb(1'b0, `REG_STATUS, 32'h0);
    check("status idle", 72'h0, 72'(rd));
    apb(1'b1, `REG_XFER_COUNT, 32'h0);
    apb(1'b0, `REG_XFER_COUNT, 32'h0);
    check("count clear", 72'h0, 72'(rd));
  endtask

  task automatic test_disabled;
    apb(1'b1, `REG_CTRL, 32'h0);
    claim_seen = 1'b0;
    i_pci_master_model.run(1, 64'h0, -1);
    repeat (4) @(posedge pclk);
    check("disabled claim", 72'h0, 72'(claim_seen));
    apb(1'b1, `REG_CTRL, 32'h1);
    apb(1'b0, `REG_CTRL, 32'h0);
    check("ctrl enable", 72'h1, 72'(rd));
    bar_hit <= 6'h00;
    claim_seen = 1'b0;
    i_pci_master_model.run(1, 64'h0, -1);
    repeat (4) @(posedge pclk);
    check("no hit claim", 72'h0, 72'(claim_seen));
    bar_hit <= 6'h01;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bar_hit = 6'h01;
    local_ready_in_n = 1'b1;
    stall = 1'b0;
    tsr_seen = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    test_single;
    test_burst;
    test_master_wait;
    test_local_stall;
    test_regs;
    test_late_irdy;
    test_disabled;
    final_report;
  end
endmodule // pci_target_memory_write_path_tb
